// file: rtl/clkpm_pkg.sv
// shared constants, types and register map of the clock and power-mode controller
package clkpm_pkg;
    // system clock period, used to turn times into cycle counts
    localparam int CLK_PERIOD_PS = 4000;
    // oscillator start-up allowance after leaving power-down
    localparam int IRC_START_NS  = 60000;
    localparam int IRC_START_CYC = (IRC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // oscillator cycles waited before code may run again
    localparam logic [15:0] MAIN_WAKE_TICKS = 16'h1000;
    localparam logic [15:0] IRC_WAKE_TICKS  = 16'h0004;
    // consecutive good reference periods before lock is reported
    localparam logic [3:0]  LOCK_REFS       = 4'h8;
    // starting period of the oscillator model minus one, in system cycles
    localparam logic [15:0] CCO_PERIOD_RST  = 16'h0010;

    // register byte offsets
    localparam logic [7:0] A_SRC    = 8'h00;
    localparam logic [7:0] A_PLLCFG = 8'h04;
    localparam logic [7:0] A_PLLCTL = 8'h08;
    localparam logic [7:0] A_CPUDIV = 8'h0C;
    localparam logic [7:0] A_USBDIV = 8'h10;
    localparam logic [7:0] A_PCLK   = 8'h14;
    localparam logic [7:0] A_PWR    = 8'h18;

    // field positions
    localparam int SRC_MAIN_EN_BIT = 2;
    localparam int PLLCFG_M_LSB    = 8;
    localparam int PLLCTL_CONN_BIT = 1;
    localparam int PCLK_DIV_LSB    = 8;
    localparam int NUM_PERIPH      = 4;

    typedef enum logic [1:0] {
        SRC_IRC  = 2'b00,
        SRC_MAIN = 2'b01,
        SRC_RTC  = 2'b10
    } src_t;

    // power-mode request codes written to the power register
    localparam logic [1:0] REQ_IDLE  = 2'h1;
    localparam logic [1:0] REQ_SLEEP = 2'h2;
    localparam logic [1:0] REQ_PDOWN = 2'h3;

    typedef enum logic [2:0] {
        PM_RUN   = 3'b000,
        PM_IDLE  = 3'b001,
        PM_SLEEP = 3'b010,
        PM_PDOWN = 3'b011,
        PM_START = 3'b100,
        PM_WAKE  = 3'b101
    } pm_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic                  cpu;
        logic                  bus;
        logic                  usb;
        logic [NUM_PERIPH-1:0] periph;
    } clk_en_t;

    typedef struct packed {
        logic main_en;
        logic irc_power;
        logic irc_out_en;
        logic rtc_en;
        logic pin_hold;
    } osc_ctl_t;

    localparam osc_ctl_t OSC_RST = '{main_en: 1'b0, irc_power: 1'b1, irc_out_en: 1'b1,
                                     rtc_en: 1'b1, pin_hold: 1'b0};

    typedef struct packed {
        logic [3:0]  sy1;
        logic [3:0]  sy2;
        logic [3:0]  sy3;
        src_t        src;
        logic        main_en;
        logic [7:0]  nsel;
        logic [14:0] msel;
        logic        pll_en;
        logic        conn_req;
        logic [7:0]  cpu_div;
        logic [3:0]  usb_div;
        logic [NUM_PERIPH-1:0]   pgate;
        logic [2*NUM_PERIPH-1:0] pdiv;
        pm_state_t   pm;
        src_t        prior;
        logic [15:0] wcnt;
        logic [15:0] mcnt;
        logic        main_ok;
        logic [7:0]  ncnt;
        logic [15:0] ccnt;
        logic [15:0] cperiod;
        logic [14:0] fcnt;
        logic [1:0]  fbs;
        logic [3:0]  lcnt;
        logic        lock;
        logic        conn;
        logic [7:0]  dcnt;
        logic [3:0]  ucnt;
        logic [2:0]  pcnt;
        logic        ack;
        logic [31:0] rdat;
        clk_en_t     en;
        osc_ctl_t    osc;
    } state_t;
endpackage : clkpm_pkg

// file: rtl/clock_pll_power_mode_control.sv
// clock source selection, pll model, clock dividers and low-power modes
//
// Notes on behaviour
// - reference divider divides the pll source by 1 to 256
// - feedback divider divides the oscillator by 1 to 32768
// - detector compares divided oscillator with reference and steers its period
// - pll off and bypassed after reset and in power-down; only software enables it
// - processor clock equals pll source unless pll active and connected
// - software may pick rtc or main oscillator as pll source
// - internal rc oscillator is selected after any reset
// - operation resumes on internal rc oscillator after power-up and power-down
// - wake-up timer guards every main oscillator start before it is used
// - idle stops processor, memory and bus clocks; peripherals run; interrupt exits
// - sleep stops all internal clocks, holds pins static, keeps state
// - sleep blocks rc oscillator output but keeps it powered
// - sleep keeps the rtc oscillator running
// - sleep entry disables and disconnects pll, clears cpu and usb dividers
// - sleep ends only on reset or a clockless wake interrupt
// - sleep wake waits 4 rc cycles, or 4096 main oscillator cycles
// - power-down does all of sleep and also powers off the rc oscillator
// - power-down wake allows 60 us rc start-up, then 4 rc cycles
// - each peripheral has its own clock gate and divider; cpu divider programmable
`timescale 1ns/1ps
`default_nettype none
module clock_pll_power_mode_control #(
    parameter int IRC_START_CYCLES = clkpm_pkg::IRC_START_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire clkpm_pkg::wb_req_t   wb_req_i,
    output var  clkpm_pkg::wb_rsp_t   wb_rsp_o,
    input  wire logic                 main_osc_i,
    input  wire logic                 rtc_osc_i,
    input  wire logic                 irc_osc_i,
    input  wire logic                 wake_irq_i,
    input  wire logic                 irq_i,
    output var  clkpm_pkg::clk_en_t   clk_en_o,
    output var  clkpm_pkg::osc_ctl_t  osc_ctl_o,
    output var  logic                 pll_lock_o
);
    import clkpm_pkg::*;

    state_t s_r;
    state_t s_nxt;

    logic        main_t;
    logic        rtc_t;
    logic        irc_t;
    logic        wake;
    logic        src_tick;
    logic        ref_t;
    logic        cco_t;
    logic        fb_t;
    logic        pll_processor_clock;
    logic        processor_clock_t;
    logic        usb_t;
    logic        req;
    logic [NUM_PERIPH-1:0] per_t;

    // byte-lane write merge
    function automatic logic [31:0] wr(input logic [31:0] old, input wb_req_t q);
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (q.sel[b]) begin
                v[8*b +: 8] = q.dat[8*b +: 8];
            end
        end
        return v;
    endfunction : wr

    // oscillator edges, only from the second synchroniser stage onward
    assign main_t = s_r.sy2[0] & ~s_r.sy3[0] & s_r.osc.main_en;
    assign rtc_t  = s_r.sy2[1] & ~s_r.sy3[1] & s_r.osc.rtc_en;
    assign irc_t  = s_r.sy2[2] & ~s_r.sy3[2] & s_r.osc.irc_out_en;
    assign wake   = s_r.sy2[3];

    // main oscillator only used once its wake-up timer has run out
    // until then the rc oscillator keeps the processor running
    assign src_tick = (s_r.src == SRC_MAIN && s_r.main_ok) ? main_t :
                      (s_r.src == SRC_RTC) ? rtc_t : irc_t;

    // pll model: reference divider, oscillator, feedback divider
    assign ref_t = src_tick && (s_r.ncnt == s_r.nsel);
    assign cco_t = s_r.pll_en && (s_r.ccnt >= s_r.cperiod);
    assign fb_t  = cco_t && (s_r.fcnt == s_r.msel);

    // processor clock path: divided pll output or the raw source
    assign pll_processor_clock = cco_t && (s_r.dcnt == s_r.cpu_div);
    assign processor_clock_t   = s_r.conn ? pll_processor_clock : src_tick;
    assign usb_t    = cco_t && (s_r.ucnt == s_r.usb_div);

    // per-peripheral gate and divide-by 1, 2, 4 or 8 off the processor clock
    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_per
        logic [1:0] dsel;
        logic [2:0] mask;
        assign dsel     = s_r.pdiv[2*i +: 2];
        assign mask     = ~(3'h7 << dsel);
        assign per_t[i] = processor_clock_t & s_r.pgate[i] & ((s_r.pcnt & mask) == mask);
    end

    // no request is taken in the cycle that carries the ack, so a strobe held into the ack cycle is not answered twice in a row
    assign req = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;

    // next-state logic for the whole block
    always_comb begin
        logic [1:0]  hits;
        logic [31:0] v;
        logic        run;
        logic        idle;
        logic        wtick;
        hits  = 2'h0;
        v     = 32'h0000_0000;
        run   = (s_r.pm == PM_RUN);
        idle  = (s_r.pm == PM_IDLE);
        wtick = 1'b0;
        s_nxt = s_r;

        // two-stage synchronisers plus edge history
        s_nxt.sy1 = {wake_irq_i, irc_osc_i, rtc_osc_i, main_osc_i};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;

        // main oscillator wake-up timer restarts whenever the oscillator is off
        if (!s_r.osc.main_en) begin
            s_nxt.mcnt    = 16'h0000;
            s_nxt.main_ok = 1'b0;
        end else if (main_t && !s_r.main_ok) begin
            s_nxt.mcnt = s_r.mcnt + 16'h0001;
            if (s_r.mcnt == MAIN_WAKE_TICKS - 16'h0001) begin
                s_nxt.main_ok = 1'b1;
            end
        end

        // reference divider counts source edges
        // nsel holds the divide value minus one
        if (src_tick) begin
            s_nxt.ncnt = ref_t ? 8'h00 : s_r.ncnt + 8'h01;
        end

        // oscillator model and frequency detector
        // period kept in system cycles: a coarse stand-in for the analog loop
        if (!s_r.pll_en) begin
            s_nxt.ccnt    = 16'h0000;
            s_nxt.cperiod = CCO_PERIOD_RST;
            s_nxt.fcnt    = 15'h0000;
            s_nxt.fbs     = 2'h0;
            s_nxt.lcnt    = 4'h0;
            s_nxt.lock    = 1'b0;
        end else begin
            s_nxt.ccnt = cco_t ? 16'h0000 : s_r.ccnt + 16'h0001;
            if (cco_t) begin
                s_nxt.fcnt = fb_t ? 15'h0000 : s_r.fcnt + 15'h0001;
            end
            if (fb_t && s_r.fbs != 2'h3) begin
                s_nxt.fbs = s_r.fbs + 2'h1;
            end
            if (ref_t) begin
                // feedback edges seen in this reference period decide the step
                hits      = (s_r.fbs == 2'h3) ? 2'h3 : s_r.fbs + {1'b0, fb_t};
                s_nxt.fbs = 2'h0;
                if (hits == 2'h0) begin
                    if (s_r.cperiod > 16'h0001) begin
                        s_nxt.cperiod = s_r.cperiod - 16'h0001;
                    end
                    s_nxt.lcnt = 4'h0;
                    s_nxt.lock = 1'b0;
                end else if (hits > 2'h1) begin
                    if (s_r.cperiod != 16'hFFFF) begin
                        s_nxt.cperiod = s_r.cperiod + 16'h0001;
                    end
                    s_nxt.lcnt = 4'h0;
                    s_nxt.lock = 1'b0;
                end else if (s_r.lcnt != LOCK_REFS) begin
                    s_nxt.lcnt = s_r.lcnt + 4'h1;
                    if (s_r.lcnt == LOCK_REFS - 4'h1) begin
                        s_nxt.lock = 1'b1;
                    end
                end
            end
        end

        // connect only at a source edge so no pulse is cut; drop at once
        // connecting without lock would hand the processor an unsettled clock
        if (!(s_r.pll_en && s_r.conn_req && s_r.lock)) begin
            s_nxt.conn = 1'b0;
        end else if (src_tick) begin
            s_nxt.conn = 1'b1;
        end

        // cpu and usb dividers run off the oscillator model
        if (cco_t) begin
            s_nxt.dcnt = pll_processor_clock ? 8'h00 : s_r.dcnt + 8'h01;
            s_nxt.ucnt = usb_t ? 4'h0 : s_r.ucnt + 4'h1;
        end
        if (processor_clock_t) begin
            s_nxt.pcnt = s_r.pcnt + 3'h1;
        end

        // wishbone register access, answered one cycle after the request
        s_nxt.ack  = req;
        s_nxt.rdat = 32'h0000_0000;
        if (req) begin
            case (wb_req_i.adr)
                A_SRC: begin
                    v = wr({29'h0, s_r.main_en, s_r.src}, wb_req_i);
                    s_nxt.rdat = {29'h0, s_r.main_en, s_r.src};
                end
                A_PLLCFG: begin
                    v = wr({9'h0, s_r.msel, s_r.nsel}, wb_req_i);
                    s_nxt.rdat = {9'h0, s_r.msel, s_r.nsel};
                end
                A_PLLCTL: begin
                    v = wr({30'h0, s_r.conn_req, s_r.pll_en}, wb_req_i);
                    s_nxt.rdat = {27'h0, s_r.main_ok, s_r.conn, s_r.lock,
                                  s_r.conn_req, s_r.pll_en};
                end
                A_CPUDIV: begin
                    v = wr({24'h0, s_r.cpu_div}, wb_req_i);
                    s_nxt.rdat = {24'h0, s_r.cpu_div};
                end
                A_USBDIV: begin
                    v = wr({28'h0, s_r.usb_div}, wb_req_i);
                    s_nxt.rdat = {28'h0, s_r.usb_div};
                end
                A_PCLK: begin
                    v = wr({16'h0, s_r.pdiv, 4'h0, s_r.pgate}, wb_req_i);
                    s_nxt.rdat = {16'h0, s_r.pdiv, 4'h0, s_r.pgate};
                end
                A_PWR: begin
                    v = wr(32'h0000_0000, wb_req_i);
                    s_nxt.rdat = {29'h0, s_r.pm};
                end
                default: begin
                    v = 32'h0000_0000;
                end
            endcase
            if (wb_req_i.we) begin
                case (wb_req_i.adr)
                    A_SRC: begin
                        // the unused code 3 leaves the selection unchanged
                        if (v[1:0] != 2'h3) begin
                            s_nxt.src = src_t'(v[1:0]);
                        end
                        s_nxt.main_en = v[SRC_MAIN_EN_BIT];
                    end
                    A_PLLCFG: begin
                        s_nxt.nsel = v[7:0];
                        s_nxt.msel = v[PLLCFG_M_LSB +: 15];
                    end
                    A_PLLCTL: begin
                        s_nxt.pll_en   = v[0];
                        s_nxt.conn_req = v[PLLCTL_CONN_BIT];
                    end
                    A_CPUDIV: begin
                        s_nxt.cpu_div = v[7:0];
                    end
                    A_USBDIV: begin
                        s_nxt.usb_div = v[3:0];
                    end
                    A_PCLK: begin
                        s_nxt.pgate = v[NUM_PERIPH-1:0];
                        s_nxt.pdiv  = v[PCLK_DIV_LSB +: 2*NUM_PERIPH];
                    end
                    A_PWR: begin
                        if (run && v[1:0] == REQ_IDLE) begin
                            s_nxt.pm = PM_IDLE;
                        end else if (run && (v[1:0] == REQ_SLEEP || v[1:0] == REQ_PDOWN)) begin
                            // pll enable, connect and the cpu and usb dividers lose their setting on the way down
                            s_nxt.pll_en   = 1'b0;
                            s_nxt.conn_req = 1'b0;
                            s_nxt.conn     = 1'b0;
                            s_nxt.cpu_div  = 8'h00;
                            s_nxt.usb_div  = 4'h0;
                            s_nxt.prior    = (s_r.src == SRC_MAIN && s_r.main_ok) ?
                                             SRC_MAIN : SRC_IRC;
                            s_nxt.pm       = (v[1:0] == REQ_PDOWN) ? PM_PDOWN : PM_SLEEP;
                        end
                    end
                    default: begin
                        s_nxt.src = s_r.src;
                    end
                endcase
            end
        end

        // power-mode sequencing
        case (s_r.pm)
            PM_RUN: begin
                s_nxt.wcnt = 16'h0000;
            end
            PM_IDLE: begin
                if (irq_i) begin
                    s_nxt.pm = PM_RUN;
                end
            end
            PM_SLEEP: begin
                if (wake) begin
                    s_nxt.pm   = PM_WAKE;
                    s_nxt.wcnt = 16'h0000;
                end
            end
            PM_PDOWN: begin
                if (wake) begin
                    // always come back on the rc oscillator
                    s_nxt.pm    = PM_START;
                    s_nxt.src   = SRC_IRC;
                    s_nxt.prior = SRC_IRC;
                    s_nxt.wcnt  = 16'h0000;
                end
            end
            PM_START: begin
                // the rc oscillator is dark here, so start-up is timed in system cycles
                s_nxt.wcnt = s_r.wcnt + 16'h0001;
                if (s_r.wcnt == 16'(IRC_START_CYCLES - 1)) begin
                    s_nxt.pm   = PM_WAKE;
                    s_nxt.wcnt = 16'h0000;
                end
            end
            PM_WAKE: begin
                // an rtc prior source counts rc edges; the slow crystal would stall the wake
                wtick = (s_r.prior == SRC_MAIN) ? main_t : irc_t;
                if (wtick) begin
                    s_nxt.wcnt = s_r.wcnt + 16'h0001;
                    if (s_r.wcnt == ((s_r.prior == SRC_MAIN) ?
                                     MAIN_WAKE_TICKS : IRC_WAKE_TICKS) - 16'h0001) begin
                        s_nxt.pm = PM_RUN;
                    end
                end
            end
            default: begin
                s_nxt.pm = PM_RUN;
            end
        endcase

        // oscillator controls follow the next power state
        s_nxt.osc.main_en    = s_nxt.main_en &&
                               !(s_nxt.pm == PM_SLEEP || s_nxt.pm == PM_PDOWN);
        s_nxt.osc.irc_power  = (s_nxt.pm != PM_PDOWN);
        s_nxt.osc.irc_out_en = !(s_nxt.pm == PM_SLEEP || s_nxt.pm == PM_PDOWN ||
                                 s_nxt.pm == PM_START);
        s_nxt.osc.rtc_en     = 1'b1;
        s_nxt.osc.pin_hold   = !(s_nxt.pm == PM_RUN || s_nxt.pm == PM_IDLE);

        // clock enables follow the next power state, as the oscillator controls do,
        // so no pulse slips out in the cycle in which the pins become held
        // idle keeps peripherals, sleep and beyond stop all
        run  = (s_nxt.pm == PM_RUN);
        idle = (s_nxt.pm == PM_IDLE);
        s_nxt.en.cpu    = run & processor_clock_t;
        s_nxt.en.bus    = run & processor_clock_t;
        s_nxt.en.usb    = (run | idle) & usb_t;
        s_nxt.en.periph = (run | idle) ? per_t : '0;
    end

    // state register; reset brings back rc source with pll off
    // only the oscillator controls differ from all-zero after reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r     <= '0;
            s_r.osc <= OSC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_rsp_o.ack = s_r.ack;
    assign wb_rsp_o.dat = s_r.rdat;
    assign clk_en_o     = s_r.en;
    assign osc_ctl_o    = s_r.osc;
    assign pll_lock_o   = s_r.lock;
endmodule : clock_pll_power_mode_control
`default_nettype wire

// file: testbench/clkpm_props.sv
// bound assertion checker for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module clkpm_props (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire clkpm_pkg::wb_req_t  wb_req_i,
    input wire clkpm_pkg::wb_rsp_t  wb_rsp_o,
    input wire clkpm_pkg::clk_en_t  clk_en_o,
    input wire clkpm_pkg::osc_ctl_t osc_ctl_o,
    input wire logic                pll_lock_o
);
    import clkpm_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // bus answers exactly one cycle after a taken request
    a_ack_follows_req: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack)
        |=> wb_rsp_o.ack) else $error("ack did not follow request");
    a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    a_dat_idle_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
        else $error("read data not zero outside ack");
    // reset must not be masked here, it is the cause being checked
    a_reset_state: assert property (disable iff (1'b0) reset_i |=> (osc_ctl_o == OSC_RST
        && !pll_lock_o && clk_en_o == '0)) else $error("reset state wrong");
    // held pins cover sleep, power-down and the wake counts: nothing ticks, rtc on
    a_hold_no_clock: assert property (osc_ctl_o.pin_hold |-> clk_en_o == '0)
        else $error("clock enable during sleep");
    // main is off on the way down and all through power-down; a main wake count runs it
    a_hold_main_off: assert property (($rose(osc_ctl_o.pin_hold)
        || (osc_ctl_o.pin_hold && !osc_ctl_o.irc_power)) |-> !osc_ctl_o.main_en)
        else $error("main oscillator on during sleep");
    a_hold_rtc_on: assert property (osc_ctl_o.pin_hold |-> osc_ctl_o.rtc_en)
        else $error("rtc oscillator stopped during sleep");
    // the wake count reopens the rc output while pins stay held, so entry is checked
    a_irc_off_blocked: assert property (($rose(osc_ctl_o.pin_hold)
        || !osc_ctl_o.irc_power) |-> !osc_ctl_o.irc_out_en)
        else $error("rc output open while held");
endmodule : clkpm_props
bind clock_pll_power_mode_control clkpm_props u_clkpm_props (.clk_i(clk_i),
    .reset_i(reset_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .clk_en_o(clk_en_o),
    .osc_ctl_o(osc_ctl_o), .pll_lock_o(pll_lock_o));
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clkpm_pkg::*;
    logic        clk_i    = 1'b0;
    logic        reset_i  = 1'b1;
    wb_req_t     wb_req_i = '0;
    wb_rsp_t     wb_rsp_o;
    clk_en_t     clk_en_o;
    osc_ctl_t    osc_ctl_o;
    logic        pll_lock_o;
    logic        internal_rc_oscillator      = 1'b0;
    logic        rtc      = 1'b0;
    logic        wake_irq = 1'b0;
    logic        irq      = 1'b0;
    logic [1:0]  tick     = 2'h0;
    logic [31:0] q;
    int          failures = 0;
    int          n_compared = 0;
    int          ncpu = 0;
    int          nper = 0;

    clock_pll_power_mode_control #(.IRC_START_CYCLES(20)) u_clock_pll_power_mode_control (
        .clk_i(clk_i), .reset_i(reset_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
        .main_osc_i(tick[1]), .rtc_osc_i(rtc), .irc_osc_i(internal_rc_oscillator), .wake_irq_i(wake_irq),
        .irq_i(irq), .clk_en_o(clk_en_o), .osc_ctl_o(osc_ctl_o), .pll_lock_o(pll_lock_o));

    always #2 clk_i = ~clk_i;
    // free-running oscillators: rc period 8 clocks, rtc 16, main (tick[1]) 4
    always @(posedge clk_i) begin
        tick <= tick + 2'h1;
        if (tick == 2'h3) begin
            internal_rc_oscillator <= ~internal_rc_oscillator;
            rtc <= rtc ^ internal_rc_oscillator;
        end
    end
    // counted on the falling edge so registered pulses are settled
    always @(negedge clk_i) begin
        ncpu += clk_en_o.cpu;
        nper += clk_en_o.periph[0];
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // one classic cycle; ack and read data are taken at the rising edge that sees ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp_o.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            print_verdict();
        end
        q = wb_rsp_o.dat;
        wb_req_i <= '0;
    endtask : wb
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask : rd
    task automatic wait_cnt(input int n, input bit clr);
        if (clr) begin
            ncpu = 0;
            nper = 0;
        end
        repeat (n) @(posedge clk_i);
    endtask : wait_cnt

    task automatic t_reset;
        chk("osc_ctl", 32'(osc_ctl_o), 32'(OSC_RST));
        chk("lock", 32'(pll_lock_o), 32'h0);
        rd("src", A_SRC, 32'h0);
        rd("pllctl", A_PLLCTL, 32'h0);
        rd("unmapped", 8'hFC, 32'h0);
        wb(1'b1, A_PLLCFG, 32'h007FFFFF);
        rd("pllcfg_max", A_PLLCFG, 32'h007FFFFF);
        wb(1'b1, A_PLLCFG, 32'h0);
        rd("pllcfg_min", A_PLLCFG, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_bypass;
        wait_cnt(80, 1'b1);
        chk("cpu_ticks", 32'(ncpu >= 9 && ncpu <= 11), 32'h1);
        wb(1'b1, A_SRC, 32'h2);
        rd("src_rtc", A_SRC, 32'h2);
        wait_cnt(48, 1'b1);
        chk("rtc_ticks", 32'(ncpu), 32'h3);
        wb(1'b1, A_SRC, 32'h0);
        $display("test bypass done");
    endtask : t_bypass
    task automatic t_idle;
        wb(1'b1, A_PCLK, 32'h1);
        wb(1'b1, A_PWR, 32'(REQ_IDLE));
        rd("pwr_idle", A_PWR, 32'h1);
        wait_cnt(80, 1'b1);
        chk("idle_cpu", 32'(ncpu), 32'h0);
        chk("idle_per", 32'(nper > 0), 32'h1);
        irq <= 1'b1;
        wait_cnt(2, 1'b0);
        irq <= 1'b0;
        rd("pwr_run", A_PWR, 32'h0);
        $display("test idle done");
    endtask : t_idle
    task automatic t_main;
        wb(1'b1, A_SRC, 32'h5);
        wait_cnt(80, 1'b1);
        chk("main_early", 32'(ncpu >= 9 && ncpu <= 11), 32'h1);
        wait_cnt(16400, 1'b0);
        rd("main_ok", A_PLLCTL, 32'h10);
        wait_cnt(80, 1'b1);
        chk("main_ticks", 32'(ncpu), 32'h14);
        wb(1'b1, A_SRC, 32'h0);
        $display("test main oscillator done");
    endtask : t_main
    task automatic t_pll;
        wb(1'b1, A_PLLCFG, 32'h0);
        wb(1'b1, A_PLLCTL, 32'h1);
        wait_cnt(1000, 1'b0);
        chk("pll_lock", 32'(pll_lock_o), 32'h1);
        wb(1'b1, A_PLLCTL, 32'h3);
        wait_cnt(16, 1'b0);
        rd("pll_conn", A_PLLCTL, 32'hF);
        wb(1'b1, A_CPUDIV, 32'h1);
        wait_cnt(80, 1'b1);
        chk("pll_div_ticks", 32'(ncpu), 32'h5);
        $display("test pll done");
    endtask : t_pll
    task automatic t_sleep;
        wb(1'b1, A_PLLCTL, 32'h1);
        wb(1'b1, A_CPUDIV, 32'h5);
        wb(1'b1, A_PWR, 32'(REQ_SLEEP));
        wait_cnt(40, 1'b1);
        chk("sleep_ticks", 32'(ncpu + nper), 32'h0);
        chk("sleep_osc", 32'(osc_ctl_o), 32'h0B);
        wake_irq <= 1'b1;
        wait_cnt(4, 1'b0);
        wake_irq <= 1'b0;
        rd("pwr_wake", A_PWR, 32'h5);
        wait_cnt(60, 1'b0);
        rd("pwr_resumed", A_PWR, 32'h0);
        rd("pll_cleared", A_PLLCTL, 32'h0);
        rd("cpudiv_cleared", A_CPUDIV, 32'h0);
        wb(1'b1, A_PLLCFG, 32'h0);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_pdown;
        wb(1'b1, A_PLLCTL, 32'h1);
        wb(1'b1, A_PWR, 32'(REQ_PDOWN));
        wait_cnt(10, 1'b0);
        chk("pdown_osc", 32'(osc_ctl_o), 32'h03);
        wake_irq <= 1'b1;
        wait_cnt(10, 1'b0);
        wake_irq <= 1'b0;
        rd("pwr_start", A_PWR, 32'h4);
        wait_cnt(14, 1'b0);
        rd("pwr_count", A_PWR, 32'h5);
        wait_cnt(60, 1'b0);
        rd("pwr_back", A_PWR, 32'h0);
        rd("pll_off", A_PLLCTL, 32'h0);
        $display("test power-down done");
    endtask : t_pdown

    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_bypass();
        t_idle();
        t_main();
        t_pll();
        t_sleep();
        t_pdown();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
